/* File: rtl/spp_pkg.sv */
// constants and types for the sixteen pin parallel port
//Contract
// - select bit 0 port, 1 alternate
// - data bus bit four strap sets selection
// - fixed alternate function per select bit
// - upper port pins beside address pins
// - transfer in progress spans back-to-back cycles
// - modifier outputs follow transfer kind
// - transfer type driven only as master
// - direction bit 0 input, 1 output
// - alternate pins ignore data and direction
// - input pin read returns pin level
// - input pin write stores, pin untouched
// - output pin driven from stored bit
// - data writable anytime, resets to zero
// - external masters reach port registers too
// - fixed offsets, sixteen bit read/write
package spp_pkg;
  localparam int unsigned PIN_W = 16;
  localparam int unsigned ADDR_W = 10;
  localparam logic [9:0] OFF_FUNC_SEL = 10'h004;
  localparam logic [9:0] OFF_DIR = 10'h244;
  localparam logic [9:0] OFF_DATA = 10'h248;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] DIR_RST = 16'h0000;
  localparam logic [15:0] FUNC_RST = 16'h0000;
  localparam logic [15:0] UNMAPPED_RD = 16'h0000;
  localparam int unsigned PIN_ADDR_LSB = 8;
  localparam int unsigned PIN_TIP = 7;
  localparam int unsigned PIN_DREQ0 = 6;
  localparam int unsigned PIN_DREQ1 = 5;
  localparam int unsigned PIN_TM_LSB = 2;
  localparam int unsigned PIN_TT_LSB = 0;
  localparam logic [2:0] TM_CPU_SPACE = 3'h0;
  localparam logic [1:0] ALT_IN_OE = 2'h0;
  localparam logic [1:0] ALT_IN_OUT = 2'h0;

  typedef enum logic [2:0] {
    KIND_NORMAL = 3'b000,
    KIND_DMA = 3'b001,
    KIND_EMUL = 3'b010,
    KIND_CPU = 3'b011,
    KIND_IACK = 3'b100
  } spp_kind_t;

  typedef enum logic [1:0] {
    TT_NORMAL = 2'b00,
    TT_DMA = 2'b01,
    TT_EMUL = 2'b10,
    TT_CPU = 2'b11
  } spp_tt_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } spp_bus_state_t;

  typedef struct packed {
    logic master;
    logic granted;
    logic in_transfer;
    spp_kind_t kind;
    logic [2:0] dma_ack;
    logic [2:0] emul_type;
    logic [2:0] iack_level;
    logic [7:0] addr_hi;
  } spp_bus_stat_t;

  typedef struct packed {
    logic sel;
    logic wr;
    logic ext;
    logic [9:0] addr;
    logic [15:0] wdata;
  } spp_reg_req_t;
endpackage : spp_pkg

/* File: rtl/spp_port.sv */
// sixteen pin parallel port with per-pin function selection
`timescale 1ns/1ps
`default_nettype none
module spp_port (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire spp_pkg::spp_reg_req_t reg_req_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_ack_o,
  input wire logic data_bus_bit_four_i,
  input wire spp_pkg::spp_bus_stat_t bus_stat_i,
  input wire logic [15:0] port_pin_i,
  output logic [15:0] port_pin_o,
  output logic [15:0] port_pin_oe_o,
  output logic [1:0] dma_request_in_o,
  output logic [15:0] pin_function_select_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [15:0] pin_function_select;
  logic [15:0] port_pin_direction;
  logic [15:0] port_pin_data;
  logic strap_done;
  spp_pkg::spp_bus_state_t state;
  spp_pkg::spp_bus_state_t next_state;
  logic [15:0] pin_sync;

  ////////////////////////////////////////////////////////////////////////////
  // input synchroniser

  spp_sync #(
    .W(spp_pkg::PIN_W)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(port_pin_i),
    .q_o(pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register bus decode

  wire take = reg_req_i.sel && (state == spp_pkg::BUS_IDLE) && strap_done;
  wire take_wr = take && reg_req_i.wr;
  // external and internal masters decode alike
  wire hit_func = (reg_req_i.addr == spp_pkg::OFF_FUNC_SEL);
  wire hit_dir = (reg_req_i.addr == spp_pkg::OFF_DIR);
  wire hit_data = (reg_req_i.addr == spp_pkg::OFF_DATA);
  wire wr_func = take_wr && hit_func;
  wire wr_dir = take_wr && hit_dir;
  wire wr_data = take_wr && hit_data;

  logic [15:0] data_view;
  logic [15:0] next_rdata;

  always_comb begin
    if (hit_func) begin
      next_rdata = pin_function_select;
    end else if (hit_dir) begin
      next_rdata = port_pin_direction;
    end else if (hit_data) begin
      next_rdata = data_view;
    end else begin
      next_rdata = spp_pkg::UNMAPPED_RD;
    end
  end

  always_comb begin
    case (state)
      spp_pkg::BUS_IDLE: begin
        next_state = take ? spp_pkg::BUS_ACK : spp_pkg::BUS_IDLE;
      end
      spp_pkg::BUS_ACK: begin
        next_state = spp_pkg::BUS_IDLE;
      end
      default: begin
        next_state = spp_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= spp_pkg::BUS_IDLE;
      reg_rdata_o <= spp_pkg::UNMAPPED_RD;
    end else begin
      state <= next_state;
      if (take && !reg_req_i.wr) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  assign reg_ack_o = (state == spp_pkg::BUS_ACK);

  ////////////////////////////////////////////////////////////////////////////
  // function select, loaded from the strap once after reset release

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strap_done <= 1'b0;
      pin_function_select <= spp_pkg::FUNC_RST;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      pin_function_select <= {spp_pkg::PIN_W{data_bus_bit_four_i}};
    end else if (wr_func) begin
      pin_function_select <= reg_req_i.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_pin_direction <= spp_pkg::DIR_RST;
    end else if (wr_dir) begin
      port_pin_direction <= reg_req_i.wdata;
    end
  end

  // accepted whatever the selection or direction
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_pin_data <= spp_pkg::DATA_RST;
    end else if (wr_data) begin
      port_pin_data <= reg_req_i.wdata;
    end
  end

  assign pin_function_select_o = pin_function_select;

  ////////////////////////////////////////////////////////////////////////////
  // alternate system functions

  wire [2:0] tm_val =
    (bus_stat_i.kind == spp_pkg::KIND_DMA) ? bus_stat_i.dma_ack :
    (bus_stat_i.kind == spp_pkg::KIND_EMUL) ? bus_stat_i.emul_type :
    (bus_stat_i.kind == spp_pkg::KIND_IACK) ? bus_stat_i.iack_level :
    spp_pkg::TM_CPU_SPACE;
  wire [1:0] tt_val =
    (bus_stat_i.kind == spp_pkg::KIND_DMA) ? spp_pkg::TT_DMA :
    (bus_stat_i.kind == spp_pkg::KIND_EMUL) ? spp_pkg::TT_EMUL :
    (bus_stat_i.kind == spp_pkg::KIND_CPU) ? spp_pkg::TT_CPU :
    (bus_stat_i.kind == spp_pkg::KIND_IACK) ? spp_pkg::TT_CPU :
    spp_pkg::TT_NORMAL;
  // level from the bus controller stays high across back-to-back cycles
  wire tip_val = bus_stat_i.granted && bus_stat_i.in_transfer;
  wire mst = bus_stat_i.master;

  // pin order 15..0: address hi, tip, request inputs, modifiers, type
  wire [15:0] alt_out = {bus_stat_i.addr_hi, tip_val, spp_pkg::ALT_IN_OUT,
                         tm_val, tt_val};
  wire [15:0] alt_oe = {{8{mst}}, 1'b1, spp_pkg::ALT_IN_OE,
                        {3{mst}}, {2{mst}}};

  ////////////////////////////////////////////////////////////////////////////
  // per-pin multiplexing

  logic [15:0] next_pin_out;
  logic [15:0] next_pin_oe;

  genvar b;
  generate
    for (b = 0; b < spp_pkg::PIN_W; b++) begin : g_pin
      // each pin decided by its own select bit only
      assign next_pin_out[b] = pin_function_select[b] ? alt_out[b]
                                                      : port_pin_data[b];
      assign next_pin_oe[b] = pin_function_select[b] ? alt_oe[b]
                                                     : port_pin_direction[b];
      assign data_view[b] = (!pin_function_select[b] && !port_pin_direction[b])
                            ? pin_sync[b] : port_pin_data[b];
    end
  endgenerate

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_pin_o <= 16'h0000;
      port_pin_oe_o <= 16'h0000;
    end else begin
      port_pin_o <= next_pin_out;
      port_pin_oe_o <= next_pin_oe;
    end
  end

  // request inputs reach the dma engine only when selected
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dma_request_in_o <= 2'h0;
    end else begin
      dma_request_in_o[0] <= pin_function_select[spp_pkg::PIN_DREQ0]
                             && pin_sync[spp_pkg::PIN_DREQ0];
      dma_request_in_o[1] <= pin_function_select[spp_pkg::PIN_DREQ1]
                             && pin_sync[spp_pkg::PIN_DREQ1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_take_read_data;
    take && !reg_req_i.wr && hit_data;
  endsequence

  sequence s_ack_pulse;
    reg_ack_o ##1 !reg_ack_o;
  endsequence

  a_bus_ack_pulse: assert property (take |=> s_ack_pulse)
    else $error("ack is not a single cycle after a taken request");

  a_strap_load_sel: assert property ($rose(strap_done) |->
      pin_function_select == {16{$past(data_bus_bit_four_i)}})
    else $error("function select does not follow the strap");

  a_data_write_any: assert property (wr_data |=>
      port_pin_data == $past(reg_req_i.wdata))
    else $error("data register missed a write");

  a_out_pin_data: assert property (
      (!pin_function_select[3] && port_pin_direction[3]) |=>
      (port_pin_o[3] == $past(port_pin_data[3])) && port_pin_oe_o[3])
    else $error("output port pin does not show stored bit");

  a_in_pin_float: assert property (
      (!pin_function_select[0] && !port_pin_direction[0]) |=> !port_pin_oe_o[0])
    else $error("input port pin is driven");

  a_read_in_level: assert property (
      (s_take_read_data and
       (!pin_function_select[1] && !port_pin_direction[1] && $past(strap_done))) |=>
      reg_rdata_o[1] == $past(port_pin_i[1], 3))
    else $error("input read does not return pin level");

  a_alt_addr_pin: assert property (
      (pin_function_select[15] && mst) |=>
      port_pin_o[15] == $past(bus_stat_i.addr_hi[7]) && port_pin_oe_o[15])
    else $error("address pin does not carry the address");

  a_mixed_addr_port: assert property (
      (pin_function_select[9:8] == 2'b11 && pin_function_select[15:10] == 6'h00
       && port_pin_direction[15:10] == 6'h3f) |=>
      port_pin_o[15:10] == $past(port_pin_data[15:10]))
    else $error("upper port pins lost beside address pins");

  a_tip_follow: assert property (pin_function_select[7] |=>
      port_pin_o[7] == $past(tip_val) && port_pin_oe_o[7])
    else $error("transfer in progress pin wrong");

  a_tm_cpu_low: assert property (
      (pin_function_select[4:2] == 3'b111 && bus_stat_i.kind == spp_pkg::KIND_CPU)
      |=> port_pin_o[4:2] == 3'h0)
    else $error("modifiers not low for cpu space");

  a_tt_not_master: assert property (
      (pin_function_select[1:0] == 2'b11 && !mst) |=> port_pin_oe_o[1:0] == 2'b00)
    else $error("transfer type driven while not master");

  a_dma_request_in_gated: assert property (!pin_function_select[6] |=>
      !dma_request_in_o[0])
    else $error("request passed while pin is a port pin");

  a_alt_sel_pin: assert property (
      (pin_function_select[12] && !mst) |=> !port_pin_oe_o[12])
    else $error("alternate pin driven by direction register");

  a_sync_delay: assert property (
      (strap_done && !pin_function_select[2] && !port_pin_direction[2]) ##0
      (!pin_function_select[2] && !port_pin_direction[2])[*3] |->
      data_view[2] == $past(port_pin_i[2], 2))
    else $error("synchroniser delay differs from two cycles");

  a_ack_from_take: assert property (
      reg_ack_o |-> $past(take))
    else $error("ack without a taken request");

  a_rdata_steady: assert property (
      !(take && !reg_req_i.wr) |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  a_read_sel_reg: assert property (
      (take && !reg_req_i.wr && hit_func) |=> reg_rdata_o == $past(pin_function_select))
    else $error("select read returns wrong value");

  a_read_dir_reg: assert property (
      (take && !reg_req_i.wr && hit_dir) |=> reg_rdata_o == $past(port_pin_direction))
    else $error("direction read returns wrong value");

  a_read_unmapped: assert property (
      (take && !reg_req_i.wr && !hit_func && !hit_dir && !hit_data) |=>
      reg_rdata_o == spp_pkg::UNMAPPED_RD)
    else $error("unmapped read returns nonzero");

  a_read_out_stored: assert property (
      (s_take_read_data and (!pin_function_select[3] && port_pin_direction[3])) |=>
      reg_rdata_o[3] == $past(port_pin_data[3]))
    else $error("output pin read does not return stored bit");

  a_read_alt_stored: assert property (
      (s_take_read_data and pin_function_select[12]) |=>
      reg_rdata_o[12] == $past(port_pin_data[12]))
    else $error("alternate pin read does not return stored bit");

  a_func_write: assert property (
      wr_func |=> pin_function_select == $past(reg_req_i.wdata))
    else $error("select register missed a write");

  a_dir_write: assert property (
      wr_dir |=> port_pin_direction == $past(reg_req_i.wdata))
    else $error("direction register missed a write");

  a_data_hold: assert property (
      !wr_data |=> $stable(port_pin_data))
    else $error("data register changed without a write");

  a_port_oe_dir: assert property (
      !pin_function_select[5] |=> port_pin_oe_o[5] == $past(port_pin_direction[5]))
    else $error("port pin enable does not follow direction");

  a_dma_request_in_pin_float: assert property (
      pin_function_select[6] |=> !port_pin_oe_o[6] && !port_pin_o[6])
    else $error("request input pin is driven");

  a_tm_dma_ack: assert property (
      (pin_function_select[4:2] == 3'b111 && bus_stat_i.kind == spp_pkg::KIND_DMA) |=>
      port_pin_o[4:2] == $past(bus_stat_i.dma_ack))
    else $error("modifiers do not carry dma acknowledge");

  a_tm_iack_level: assert property (
      (pin_function_select[4:2] == 3'b111 && bus_stat_i.kind == spp_pkg::KIND_IACK) |=>
      port_pin_o[4:2] == $past(bus_stat_i.iack_level))
    else $error("modifiers do not carry the acknowledged level");

  a_tt_master_dma: assert property (
      (pin_function_select[1:0] == 2'b11 && mst && bus_stat_i.kind == spp_pkg::KIND_DMA) |=>
      port_pin_o[1:0] == spp_pkg::TT_DMA && port_pin_oe_o[1:0] == 2'b11)
    else $error("transfer type wrong while master");

  a_tip_idle_low: assert property (
      (pin_function_select[7] && bus_stat_i.granted && !bus_stat_i.in_transfer) |=> !port_pin_o[7])
    else $error("transfer in progress high on an idle cycle");

  a_dma_request_in_follow: assert property (
      (pin_function_select[5] && $past(strap_done)) |=>
      dma_request_in_o[1] == $past(port_pin_i[5], 3))
    else $error("request input does not follow its pin");

endmodule : spp_port
`default_nettype wire

/* File: rtl/spp_sync.sv */
// two flip-flop level synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module spp_sync #(
  parameter int unsigned W = 16
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : spp_sync
`default_nettype wire

/* File: testbench/spp_pins_model.sv */
// behavioural external devices on the sixteen port pins
`timescale 1ns/1ps
`default_nettype none
module spp_pins_model (
  input wire logic [15:0] pin_o_i,
  input wire logic [15:0] pin_oe_i,
  input wire logic [15:0] ext_level_i,
  output logic [15:0] pin_i_o
);
  // peripheral drives wherever the port does not, dma requests included
  assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_level_i);
endmodule : spp_pins_model
`default_nettype wire

/* File: testbench/spp_port_test.sv */
// self-checking bench for the sixteen pin parallel port
`timescale 1ns/1ps
`default_nettype none
module spp_port_test;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic strap = 1'b0;
  spp_pkg::spp_reg_req_t req = '0;
  spp_pkg::spp_bus_stat_t bst = '0;
  logic [15:0] ext = 16'h3c3c;
  logic [15:0] pin_in, pin_out, pin_oe, fsel, rd, r;
  logic [1:0] dma_request_in;
  logic ack;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  spp_pkg::spp_kind_t kinds[5] = '{spp_pkg::KIND_NORMAL, spp_pkg::KIND_DMA,
    spp_pkg::KIND_EMUL, spp_pkg::KIND_CPU, spp_pkg::KIND_IACK};

  spp_port i_spp_port (.clk_i(clk_i), .resetn_i(resetn_i), .reg_req_i(req),
    .reg_rdata_o(rd), .reg_ack_o(ack), .data_bus_bit_four_i(strap), .bus_stat_i(bst),
    .port_pin_i(pin_in), .port_pin_o(pin_out), .port_pin_oe_o(pin_oe),
    .dma_request_in_o(dma_request_in), .pin_function_select_o(fsel));
  spp_pins_model i_spp_pins_model (.pin_o_i(pin_out), .pin_oe_i(pin_oe),
    .ext_level_i(ext), .pin_i_o(pin_in));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : cmp

  // one register access, held until the acknowledge is sampled
  task automatic acc(input logic wr, input logic ex, input logic [9:0] a,
                     input logic [15:0] wd);
    int k;
    @(posedge clk_i);
    req <= '{sel: 1'b1, wr: wr, ext: ex, addr: a, wdata: wd};
    for (k = 0; k < 8; k++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    r = rd;
    req.sel <= 1'b0;
    cmp({15'h0, ack}, 16'h0001, "ack");
  endtask : acc

  // strap held steady across the release edge
  task automatic do_reset(input logic s);
    resetn_i <= 1'b0;
    strap <= s;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask : do_reset

  function automatic logic [4:0] alt_low(input spp_pkg::spp_kind_t k);
    case (k)
      spp_pkg::KIND_DMA: return {3'h5, 2'b01};
      spp_pkg::KIND_EMUL: return {3'h6, 2'b10};
      spp_pkg::KIND_IACK: return {3'h3, 2'b11};
      spp_pkg::KIND_CPU: return {3'h0, 2'b11};
      default: return 5'h00;
    endcase
  endfunction : alt_low

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(1'b0);
    cmp(fsel, 16'h0000, "strap low");
    acc(1'b0, 1'b0, spp_pkg::OFF_FUNC_SEL, 16'h0000);
    cmp(r, 16'h0000, "sel read");
    acc(1'b0, 1'b0, spp_pkg::OFF_DATA, 16'h0000);
    cmp(r, 16'h3c3c, "input read");
    acc(1'b1, 1'b0, spp_pkg::OFF_DATA, 16'h00a0);
    repeat (2) @(posedge clk_i);
    cmp(pin_oe, 16'h0000, "input pin driven");
    acc(1'b1, 1'b0, spp_pkg::OFF_DIR, 16'h00f0);
    repeat (2) @(posedge clk_i);
    cmp(pin_oe, 16'h00f0, "dir");
    cmp({12'h0, pin_in[7:4]}, 16'h000a, "out level");
    acc(1'b0, 1'b0, spp_pkg::OFF_DATA, 16'h0000);
    cmp(r, 16'h3cac, "mixed read");
    acc(1'b0, 1'b0, 10'h100, 16'h0000);
    cmp(r, 16'h0000, "unmapped");
    acc(1'b1, 1'b1, spp_pkg::OFF_DIR, 16'hffff);
    acc(1'b0, 1'b1, spp_pkg::OFF_DIR, 16'h0000);
    cmp(r, 16'hffff, "ext dir");
    acc(1'b1, 1'b0, spp_pkg::OFF_DATA, 16'ha400);
    bst <= '{master: 1'b1, granted: 1'b1, in_transfer: 1'b1, kind: spp_pkg::KIND_NORMAL,
      dma_ack: 3'h5, emul_type: 3'h6, iack_level: 3'h3, addr_hi: 8'ha5};
    acc(1'b1, 1'b0, spp_pkg::OFF_FUNC_SEL, 16'h03ff);
    repeat (4) @(posedge clk_i);
    cmp(pin_out[15:8], 16'h00a5, "addr and port");
    cmp(pin_oe, 16'hff9f, "alt enables");
    cmp({15'h0, pin_out[7]}, 16'h0001, "tip");
    cmp({14'h0, dma_request_in}, 16'h0002, "dma req");
    acc(1'b1, 1'b0, spp_pkg::OFF_DATA, 16'h5bff);
    foreach (kinds[i]) begin
      bst.kind <= kinds[i];
      repeat (3) @(posedge clk_i);
      cmp({11'h0, pin_out[4:0]}, {11'h0, alt_low(kinds[i])}, "tm tt");
    end
    cmp(pin_out[15:8], 16'h0059, "alt keep");
    bst.master <= 1'b0;
    bst.in_transfer <= 1'b0;
    repeat (3) @(posedge clk_i);
    cmp(pin_oe, 16'hfc80, "not master");
    cmp({15'h0, pin_out[7]}, 16'h0000, "tip idle");
    do_reset(1'b1);
    cmp(fsel, 16'hffff, "strap high");
    acc(1'b0, 1'b0, spp_pkg::OFF_DATA, 16'h0000);
    cmp(r, 16'h0000, "data reset");
    wrap_up();
  end
endmodule : spp_port_test
`default_nettype wire
